// File: p3mux_board.sv
`timescale 1ns/100ps
`default_nettype none
module p3mux_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_oe,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  // Pads nobody drives float up through the weak pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_oe) |
                  (~pin_oe & ext_oe & ext_val);
endmodule // p3mux_board
`default_nettype wire

// File: p3mux_defs.vh
`ifndef P3MUX_DEFS_VH
`define P3MUX_DEFS_VH

// ----------------------------------------------------------------
// Port 3 pin positions
// ----------------------------------------------------------------
`define P3M_PIN_RXD      0
`define P3M_PIN_TXD      1
`define P3M_PIN_IRQ0     2
`define P3M_PIN_IRQ1     3
`define P3M_PIN_T0       4
`define P3M_PIN_T1       5
`define P3M_PIN_WR       6
`define P3M_PIN_RD       7

// ----------------------------------------------------------------
// Port 2 pins that may carry the PWM outputs
// ----------------------------------------------------------------
`define P3M_P2_PWM_A     6
`define P3M_P2_PWM_B     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define P3M_LATCH_RST    8'hFF
`define P3M_BIT_RST      1'h1
`define P3M_ZERO         1'h0
`define P3M_PWM2_IDLE    2'h0

`endif

// File: p3mux_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module p3mux_monitor (
  input wire       clk_sys,
  input wire       rst,
  input wire [7:0] pin_in,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pin_state,
  input wire       uart_sync_mode,
  input wire       uart_txd,
  input wire       uart_shift_clk,
  input wire       xmem_write,
  input wire       xmem_read,
  input wire       pwm_enable,
  input wire       pwm_on_port2,
  input wire       pwm_out_a,
  input wire       pwm_out_b,
  input wire [1:0] port2_pwm_out,
  input wire       ext_clk_enable,
  input wire       external_clock_in,
  input wire       timer_zero_count_in,
  input wire       timer_one_count_in
);
  // Saturates at 3: two clean edges of pad history exist
  reg [1:0] up_r;
  always @(posedge clk_sys)
    if (rst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wr_strobe_a: assert property (
    xmem_write |=> pin_oe[6] && !pin_out[6]) else $error("write strobe idle");
  rd_strobe_a: assert property (
    xmem_read |=> pin_oe[7] && !pin_out[7]) else $error("read strobe idle");
  txd_role_a: assert property (1 |=> pin_oe[1] && pin_out[1] ==
    ($past(uart_sync_mode) ? $past(uart_shift_clk) : $past(uart_txd)))
    else $error("transmit pin wrong source");
  pwm_port2_a: assert property (pwm_enable && pwm_on_port2 |=>
    port2_pwm_out == {$past(pwm_out_b), $past(pwm_out_a)})
    else $error("pwm not on port 2");
  pwm_port3_a: assert property (pwm_enable && !pwm_on_port2 |=>
    (&pin_oe[4:3]) && pin_out[4:3] == {$past(pwm_out_a), $past(pwm_out_b)})
    else $error("pwm not on port 3");
  ext_clk_gate_a: assert property (
    !ext_clk_enable [*3] |-> !external_clock_in) else $error("clock leaks");
  timer_inputs_a: assert property (up_r == 2'h3 |->
    {timer_one_count_in, timer_zero_count_in} == $past(pin_in[5:4], 2))
    else $error("timer input view wrong");
  pad_state_a: assert property (
    up_r == 2'h3 |-> pin_state == $past(pin_in, 2)) else $error("pad view");
  cover property (xmem_write);
  cover property (pwm_enable && !pwm_on_port2);
  cover property (ext_clk_enable && external_clock_in);
endmodule // p3mux_monitor
bind p3mux_port3 p3mux_monitor u_p3mux_monitor (.*);
`default_nettype wire

// File: p3mux_port3.v
// How it works
// - Pins bidirectional; latch one gives weak pull-up
// - Receive pin: input async, bidirectional data sync
// - Transmit pin: data async, shift clock sync
// - Interrupt pins feed edge/level logic; priority comes from config inputs
// - First interrupt pin gates timer zero
// - Second interrupt pin gates timer one
// - Pin four is timer zero count input
// - Pin five is timer one count input
// - PWM outputs routed to port 2 or port 3
// - Pin four can clock the PWM unit
// - External clock only after config bit enables
// - Rising convert-start edge starts ADC conversion
// - Write strobe driven during external data write
// - Pin three serves as SPI slave output
// - Read strobe driven during external data read
`timescale 1ns/100ps
`default_nettype none
`include "p3mux_defs.vh"

module p3mux_port3 #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] latch_wdata,
  input  wire             latch_we,
  output reg  [WIDTH-1:0] latch_value,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pin_oe,
  output reg  [WIDTH-1:0] pin_state,
  input  wire             uart_sync_mode,
  input  wire             uart_txd,
  input  wire             uart_shift_clk,
  input  wire             uart_sync_data_out,
  input  wire             uart_sync_data_oe,
  output reg              uart_rxd,
  input  wire             irq0_edge_mode,
  input  wire             irq1_edge_mode,
  input  wire             irq0_high_prio,
  input  wire             irq1_high_prio,
  output reg              irq0_request,
  output reg              irq1_request,
  output reg              irq0_prio_level,
  output reg              irq1_prio_level,
  input  wire             timer0_gate_en,
  input  wire             timer1_gate_en,
  input  wire             timer0_run,
  input  wire             timer1_run,
  output reg              timer0_count_en,
  output reg              timer1_count_en,
  output reg              timer_zero_count_in,
  output reg              timer_one_count_in,
  input  wire             pwm_on_port2,
  input  wire             pwm_enable,
  input  wire             pwm_out_a,
  input  wire             pwm_out_b,
  output reg  [1:0]       port2_pwm_out,
  output reg              pwm_clock_in,
  input  wire             ext_clk_enable,
  output reg              external_clock_in,
  input  wire             adc_ext_start_en,
  output reg              adc_convert_start_n,
  output reg              adc_start_pulse,
  input  wire             spi_slave_mode,
  input  wire             spi_miso_out,
  output reg              spi_miso_in,
  input  wire             xmem_write,
  input  wire             xmem_read
);

  // ----------------------------------------------------------------
  // Port latch and input sampling
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] latch_r;
  reg [WIDTH-1:0] sample_r;
  reg             irq0_prev_r;
  reg             irq1_prev_r;
  reg             cnvst_prev_r;
  reg             irq0_edge_r;
  reg             irq1_edge_r;

  wire irq0_lvl   = sample_r[`P3M_PIN_IRQ0];
  wire irq1_lvl   = sample_r[`P3M_PIN_IRQ1];
  wire cnvst_lvl  = sample_r[`P3M_PIN_T1];
  wire pwm_on_p3  = pwm_enable && !pwm_on_port2;

  // ----------------------------------------------------------------
  // Falling-edge helper, shared by both interrupt inputs
  // ----------------------------------------------------------------
  function p3m_fell(input prev_lvl, input cur_lvl);
    p3m_fell = prev_lvl && !cur_lvl;
  endfunction

  always @(posedge clk_sys) begin
    if (rst) begin
      latch_r      <= `P3M_LATCH_RST;
      sample_r     <= `P3M_LATCH_RST;
      // History starts at the pull-up level: no false edge
      irq0_prev_r  <= `P3M_BIT_RST;
      irq1_prev_r  <= `P3M_BIT_RST;
      cnvst_prev_r <= `P3M_BIT_RST;
      irq0_edge_r  <= `P3M_ZERO;
      irq1_edge_r  <= `P3M_ZERO;
    end else begin
      if (latch_we) begin
        latch_r <= latch_wdata;
      end
      sample_r     <= pin_in;
      irq0_prev_r  <= irq0_lvl;
      irq1_prev_r  <= irq1_lvl;
      cnvst_prev_r <= cnvst_lvl;
      // Interrupt lines are active low; edge mode catches the fall
      irq0_edge_r  <= p3m_fell(irq0_prev_r, irq0_lvl);
      irq1_edge_r  <= p3m_fell(irq1_prev_r, irq1_lvl);
    end
  end

  // ----------------------------------------------------------------
  // Input-side alternate functions, registered
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      uart_rxd            <= `P3M_BIT_RST;
      irq0_request        <= `P3M_ZERO;
      irq1_request        <= `P3M_ZERO;
      irq0_prio_level     <= `P3M_ZERO;
      irq1_prio_level     <= `P3M_ZERO;
      timer0_count_en     <= `P3M_ZERO;
      timer1_count_en     <= `P3M_ZERO;
      timer_zero_count_in <= `P3M_BIT_RST;
      timer_one_count_in  <= `P3M_BIT_RST;
      pwm_clock_in        <= `P3M_BIT_RST;
      external_clock_in   <= `P3M_ZERO;
      adc_convert_start_n <= `P3M_BIT_RST;
      adc_start_pulse     <= `P3M_ZERO;
      spi_miso_in         <= `P3M_BIT_RST;
      latch_value         <= `P3M_LATCH_RST;
      pin_state           <= `P3M_LATCH_RST;
    end else begin
      uart_rxd        <= sample_r[`P3M_PIN_RXD];
      irq0_request    <= irq0_edge_mode ? irq0_edge_r : !irq0_lvl;
      irq1_request    <= irq1_edge_mode ? irq1_edge_r : !irq1_lvl;
      irq0_prio_level <= irq0_high_prio;
      irq1_prio_level <= irq1_high_prio;
      // Gate mode: timer counts only while its interrupt pin is high
      timer0_count_en <= timer0_run && (!timer0_gate_en || irq0_lvl);
      timer1_count_en <= timer1_run && (!timer1_gate_en || irq1_lvl);
      timer_zero_count_in <= sample_r[`P3M_PIN_T0];
      timer_one_count_in  <= sample_r[`P3M_PIN_T1];
      pwm_clock_in        <= sample_r[`P3M_PIN_T0];
      // Held low until enabled, so a floating pin clocks nothing
      external_clock_in   <= ext_clk_enable &&
                             sample_r[`P3M_PIN_T0];
      adc_convert_start_n <= cnvst_lvl;
      adc_start_pulse     <= adc_ext_start_en && !cnvst_prev_r &&
                             cnvst_lvl;
      spi_miso_in         <= sample_r[`P3M_PIN_IRQ1];
      latch_value         <= latch_r;
      pin_state           <= sample_r;
    end
  end

  // ----------------------------------------------------------------
  // Output-side pin drive, registered
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] out_nxt;
  reg [WIDTH-1:0] oe_nxt;
  integer i;

  always @* begin
    // Latch zero drives low; latch one is only the weak pull-up
    for (i = 0; i < WIDTH; i = i + 1) begin
      out_nxt[i] = latch_r[i];
      oe_nxt[i]  = !latch_r[i];
    end
    if (uart_sync_mode) begin
      out_nxt[`P3M_PIN_RXD] = uart_sync_data_out;
      oe_nxt[`P3M_PIN_RXD]  = uart_sync_data_oe;
      out_nxt[`P3M_PIN_TXD] = uart_shift_clk;
    end else begin
      out_nxt[`P3M_PIN_TXD] = uart_txd;
    end
    oe_nxt[`P3M_PIN_TXD] = `P3M_BIT_RST;
    if (pwm_on_p3) begin
      out_nxt[`P3M_PIN_T0]   = pwm_out_a;
      oe_nxt[`P3M_PIN_T0]    = `P3M_BIT_RST;
      out_nxt[`P3M_PIN_IRQ1] = pwm_out_b;
      oe_nxt[`P3M_PIN_IRQ1]  = `P3M_BIT_RST;
    end else if (spi_slave_mode) begin
      out_nxt[`P3M_PIN_IRQ1] = spi_miso_out;
      oe_nxt[`P3M_PIN_IRQ1]  = `P3M_BIT_RST;
    end
    // Strobes are active low and driven hard for the whole access
    if (xmem_write) begin
      out_nxt[`P3M_PIN_WR] = `P3M_ZERO;
      oe_nxt[`P3M_PIN_WR]  = `P3M_BIT_RST;
    end
    if (xmem_read) begin
      out_nxt[`P3M_PIN_RD] = `P3M_ZERO;
      oe_nxt[`P3M_PIN_RD]  = `P3M_BIT_RST;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pin_out       <= `P3M_LATCH_RST;
      pin_oe        <= {WIDTH{`P3M_ZERO}};
      port2_pwm_out <= `P3M_PWM2_IDLE;
    end else begin
      pin_out <= out_nxt;
      pin_oe  <= oe_nxt;
      port2_pwm_out <= (pwm_enable && pwm_on_port2) ?
                       {pwm_out_b, pwm_out_a} : `P3M_PWM2_IDLE;
    end
  end

endmodule // p3mux_port3

`default_nettype wire

// File: p3mux_port3_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module p3mux_port3_tb_top;
  logic [7:0] latch_wdata, latch_value, pin_in, pin_out, pin_oe, pin_state;
  logic [7:0] ext_oe, ext_val, adc_hits, irq_hits, p4_view, irq_view;
  logic [1:0] port2_pwm_out;
  logic clk_sys = 1'b0, rst = 1'b1, latch_we, uart_sync_mode, uart_txd;
  logic uart_shift_clk, uart_sync_data_out, uart_sync_data_oe, uart_rxd;
  logic irq0_edge_mode, irq1_edge_mode, irq0_high_prio, irq1_high_prio;
  logic irq0_request, irq1_request, irq0_prio_level, irq1_prio_level;
  logic timer0_gate_en, timer1_gate_en, timer0_run, timer1_run;
  logic timer0_count_en, timer1_count_en, timer_zero_count_in;
  logic timer_one_count_in, pwm_on_port2, pwm_enable, pwm_out_a, pwm_out_b;
  logic pwm_clock_in, ext_clk_enable, external_clock_in, adc_ext_start_en;
  logic adc_convert_start_n, adc_start_pulse, spi_slave_mode, spi_miso_out;
  logic spi_miso_in, xmem_write, xmem_read;
  int num_errors = 0;
  int comparisons = 0;
  p3mux_port3 u_p3mux_port3 (.*);
  p3mux_board u_p3mux_board (.*);
  assign p4_view = {5'h0, timer_zero_count_in, pwm_clock_in, external_clock_in};
  assign irq_view = {4'h0, irq1_request, irq0_request, irq1_prio_level,
                     irq0_prio_level};
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rst) adc_hits <= 8'h00;
    else if (adc_start_pulse === 1'b1) adc_hits <= adc_hits + 8'h01;
  // Counts edge-mode request cycles only, so level-mode time is ignored
  always @(posedge clk_sys)
    if (rst) irq_hits <= 8'h00;
    else if (irq0_edge_mode && irq0_request === 1'b1)
      irq_hits <= irq_hits + 8'h01;
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_latch;
    latch_wdata = 8'h5A;
    latch_we = 1'b1;
    tick(1);
    latch_we = 1'b0;
    tick(4);
    chk(pin_state, 8'h5A);
    chk({7'h0, uart_rxd}, 8'h00);
    chk(latch_value, 8'h5A);
    latch_wdata = 8'hFF;
    latch_we = 1'b1;
    tick(1);
    latch_we = 1'b0;
    uart_sync_mode = 1'b1;
    uart_sync_data_oe = 1'b1;
    tick(4);
    chk(pin_state, 8'hFC);
    uart_sync_mode = 1'b0;
    uart_sync_data_oe = 1'b0;
  endtask
  task automatic t_strobe;
    xmem_write = 1'b1;
    tick(4);
    chk(pin_state, 8'hBF);
    xmem_write = 1'b0;
    xmem_read = 1'b1;
    tick(4);
    chk(pin_state, 8'h7F);
    xmem_read = 1'b0;
  endtask
  task automatic t_pin4;
    ext_oe = 8'h30;
    tick(4);
    chk(p4_view, 8'h00);
    ext_val = 8'h30;
    tick(4);
    chk(p4_view, 8'h06);
    ext_clk_enable = 1'b1;
    tick(4);
    chk(p4_view, 8'h07);
  endtask
  task automatic t_adc;
    ext_val = 8'h00;
    adc_ext_start_en = 1'b1;
    tick(4);
    chk(adc_hits, 8'h00);
    ext_val = 8'h20;
    tick(5);
    chk(adc_hits, 8'h01);
    chk({7'h0, timer_one_count_in}, 8'h01);
    chk({7'h0, adc_convert_start_n}, 8'h01);
    ext_oe = 8'h00;
  endtask
  task automatic t_pwm;
    pwm_enable = 1'b1;
    pwm_on_port2 = 1'b1;
    pwm_out_a = 1'b1;
    tick(3);
    chk({6'h0, port2_pwm_out}, 8'h01);
    pwm_on_port2 = 1'b0;
    tick(4);
    chk(pin_state, 8'hF7);
    pwm_enable = 1'b0;
  endtask
  task automatic t_irq;
    irq0_high_prio = 1'b1;
    timer0_run = 1'b1;
    timer1_run = 1'b1;
    timer0_gate_en = 1'b1;
    ext_oe = 8'h0C;
    ext_val = 8'h08;
    tick(4);
    chk(irq_view, 8'h05);
    chk({6'h0, timer1_count_en, timer0_count_en}, 8'h02);
    timer1_gate_en = 1'b1;
    ext_val = 8'h04;
    tick(4);
    chk(irq_view, 8'h09);
    chk({6'h0, timer1_count_en, timer0_count_en}, 8'h01);
    irq0_edge_mode = 1'b1;
    tick(4);
    chk(irq_hits, 8'h00);
    ext_val = 8'h00;
    tick(4);
    chk(irq_hits, 8'h01);
    chk(irq_view, 8'h09);
    irq0_edge_mode = 1'b0;
    ext_oe = 8'h00;
  endtask
  task automatic t_spi;
    spi_slave_mode = 1'b1;
    tick(4);
    chk(pin_oe, 8'h0A);
    chk(pin_state, 8'hF7);
    chk({7'h0, spi_miso_in}, 8'h00);
    spi_miso_out = 1'b1;
    tick(4);
    chk(pin_state, 8'hFF);
    chk({7'h0, spi_miso_in}, 8'h01);
    spi_slave_mode = 1'b0;
  endtask
  initial begin
    {latch_wdata, ext_oe, ext_val} = 24'h0;
    {latch_we, uart_sync_mode, uart_txd, uart_shift_clk, uart_sync_data_out,
     uart_sync_data_oe, irq0_edge_mode, irq1_edge_mode, irq0_high_prio,
     irq1_high_prio, timer0_gate_en, timer1_gate_en, timer0_run, timer1_run,
     pwm_on_port2, pwm_enable, pwm_out_a, pwm_out_b, ext_clk_enable,
     adc_ext_start_en, spi_slave_mode, spi_miso_out, xmem_write,
     xmem_read} = 24'h0;
    tick(5);
    rst = 1'b0;
    uart_txd = 1'b1;
    t_latch();
    t_strobe();
    t_pin4();
    t_adc();
    t_pwm();
    t_irq();
    t_spi();
    summarize();
  end
  // Whole run is under 100 cycles; this leaves wide margin
  initial begin
    #4000;
    num_errors++;
    summarize();
  end
endmodule // p3mux_port3_tb_top
`default_nettype wire
